/* core/cpu_sysctl_and_block_move.sv */
// execution unit for system control instructions and the counted block byte move
// assumes the decoder hands one instruction per command and memory answers reads next cycle
//
// Function
// (RL1) trap pushes pc then flags, loads pc from vector, sets mask; 14/16 states
// (RL2) exception return pops flags first, then pc; all flags restored; advanced mode restores pc with the two pushed words swapped
// (RL3) power-down enters sleep, leaves flags alone, takes 2 states
// (RL4) flag load from immediate, byte register or memory word in all address forms
// (RL5) post-increment flag load reads at pointer then adds 2 to it
// (RL6) flag store to byte register or memory word, flags unchanged
// (RL7) pre-decrement flag store subtracts 2 first, writes at updated pointer
// (RL8) byte-count move skips on zero count, else copies bytes until count is zero
// (RL9) word-count move does the same loop with the 16-bit count
// (RL10) block move takes 8 states plus 4 per byte moved
// (RL11) state counts hold for on-chip code and operands
// (RL12) flag and/or/xor with immediate update all flags; no-op adds 2 to pc
`timescale 1ns/1ps
module cpu_sysctl_and_block_move import sysctl_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire op_type cmd_op_i,
	input wire mode_type cmd_mode_i,
	input wire logic cmd_advanced_i,
	input wire logic [7:0] cmd_imm_i,
	input wire logic [23:0] cmd_disp_i,
	input wire logic [31:0] cmd_pointer_i,
	input wire logic [15:0] cmd_count_i,
	input wire logic [15:0] cmd_src_i,
	input wire logic [15:0] cmd_dst_i,
	input wire logic wake_i,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic mem_byte_o,
	output logic [23:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	output logic power_down_o,
	output logic [7:0] flag_o,
	output logic [23:0] pc_o,
	output logic [31:0] sp_o,
	output logic res_valid_o,
	input wire logic res_ready_i,
	output logic [7:0] res_flag_o,
	output logic [23:0] res_pc_o,
	output logic [31:0] res_pointer_o,
	output logic [7:0] res_byte_o,
	output logic [15:0] res_count_o,
	output logic [15:0] res_src_o,
	output logic [15:0] res_dst_o
);
	logic busy, adv, done, accept, wake_meta, wake_sync;
	logic [STEP_WIDTH-1:0] step, total, next_total;
	op_type op;
	mode_type mode;
	logic [7:0] imm, flag_register, byte_reg;
	logic [23:0] pc, ea, next_ea;
	logic [31:0] stack_pointer, pointer;
	logic [15:0] count, src, dst;
	result_type head, tail, entry;
	logic head_valid, tail_valid, next_head_valid, next_tail_valid;
	logic is_move, in_loop;
	logic [15:0] moved;

	assign accept = cmd_valid_i && cmd_ready_o;
	assign done = busy && (step == total - 20'h00001);
	assign is_move = (op == block_byte_move_op) || (op == block_word_move_op);
	assign in_loop = is_move && (step >= STATES_MOVE_LOOP_START)
		&& (step < total - STATES_MOVE_LOOP_START);

	always_comb begin
		case (cmd_mode_i)
			mode_disp16: next_ea = cmd_pointer_i[23:0] + {{8{cmd_disp_i[15]}}, cmd_disp_i[15:0]};
			mode_disp24: next_ea = cmd_pointer_i[23:0] + cmd_disp_i;
			mode_step: next_ea = (cmd_op_i == flag_store_op) ?
				cmd_pointer_i[23:0] - STACK_WORD : cmd_pointer_i[23:0]; // RL5 RL7
			mode_abs16: next_ea = {{8{cmd_disp_i[15]}}, cmd_disp_i[15:0]};
			mode_abs24: next_ea = cmd_disp_i;
			default: next_ea = cmd_pointer_i[23:0];
		endcase
	end

	// figures are for on-chip code and operands; slower memory would stretch them
	always_comb begin // RL11
		next_total = STATES_SHORT;
		case (cmd_op_i)
			software_trap_op: next_total = cmd_advanced_i ? STATES_TRAP_ADVANCED : STATES_TRAP_NORMAL; // RL1
			exception_return_op: next_total = STATES_RETURN;
			block_byte_move_op: next_total = STATES_MOVE_BASE + {10'h000, cmd_count_i[7:0], 2'h0}; // RL10
			block_word_move_op: next_total = STATES_MOVE_BASE + {2'h0, cmd_count_i, 2'h0}; // RL10
			flag_load_op, flag_store_op: begin
				case (cmd_mode_i)
					mode_ind: next_total = STATES_MEM_IND;
					mode_disp16: next_total = STATES_MEM_DISP16;
					mode_disp24: next_total = STATES_MEM_DISP24;
					mode_step: next_total = STATES_MEM_STEP;
					mode_abs16: next_total = STATES_MEM_ABS16;
					mode_abs24: next_total = STATES_MEM_ABS24;
					default: next_total = STATES_SHORT;
				endcase
			end
			default: next_total = STATES_SHORT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy <= 1'b0;
			step <= '0;
			total <= STATES_SHORT;
			op <= nop_op;
			mode <= mode_imm;
			adv <= 1'b0;
			imm <= 8'h00;
			ea <= 24'h000000;
		end else if (accept) begin
			busy <= 1'b1;
			step <= '0;
			total <= next_total;
			op <= cmd_op_i;
			mode <= cmd_mode_i;
			adv <= cmd_advanced_i;
			imm <= cmd_imm_i;
			ea <= next_ea;
		end else if (done) begin
			busy <= 1'b0;
		end else if (busy) begin
			step <= step + 20'h00001;
		end
	end

	// wake arrives from a pin, so it is synchronised before use
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
			power_down_o <= 1'b0;
		end else begin
			wake_meta <= wake_i;
			wake_sync <= wake_meta;
			if (busy && op == power_down_op && step == 20'h00000)
				power_down_o <= 1'b1; // RL3
			else if (wake_sync)
				power_down_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_register <= 8'h80;
			pc <= 24'h000000;
			stack_pointer <= STACK_RESET;
		end else if (busy) begin
			case (op)
				software_trap_op: begin
					if (step == 20'h00008) begin
						flag_register[I_FLAG_BIT] <= 1'b1; // RL1
						if (adv) pc[23:16] <= mem_rdata_i[7:0];
						else pc[15:0] <= mem_rdata_i; // RL1
					end
					if (adv && step == 20'h0000A) pc[15:0] <= mem_rdata_i;
					if (done) stack_pointer <= stack_pointer - (adv ? 32'h6 : 32'h4);
				end
				exception_return_op: begin
					if (step == 20'h00002) flag_register <= mem_rdata_i[15:8]; // RL2
					if (step == 20'h00004) begin
						if (adv) pc[23:16] <= mem_rdata_i[7:0];
						else pc[15:0] <= mem_rdata_i; // RL2
					end
					if (adv && step == 20'h00006) pc[15:0] <= mem_rdata_i;
					if (done) stack_pointer <= stack_pointer + (adv ? 32'h6 : 32'h4);
				end
				flag_load_op: begin
					if (step == 20'h00000 && (mode == mode_imm || mode == mode_reg))
						flag_register <= imm; // RL4
					if (step == 20'h00002 && mode != mode_imm && mode != mode_reg)
						flag_register <= mem_rdata_i[15:8]; // RL4
				end
				flag_and_immediate_op: if (step == 20'h00000) flag_register <= flag_register & imm; // RL12
				flag_or_immediate_op: if (step == 20'h00000) flag_register <= flag_register | imm; // RL12
				flag_xor_immediate_op: if (step == 20'h00000) flag_register <= flag_register ^ imm; // RL12
				nop_op: if (step == 20'h00000) pc <= pc + 24'h000002; // RL12
				default: ;
			endcase
		end
	end

	// memory requests are registered, so read data is captured two edges after issue
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_byte_o <= 1'b0;
			mem_addr_o <= 24'h000000;
			mem_wdata_o <= 16'h0000;
		end else begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_byte_o <= 1'b0;
			if (busy) begin
				case (op)
					software_trap_op: begin
						if (step == 20'h00000) begin // RL1
							mem_req_o <= 1'b1;
							mem_we_o <= 1'b1;
							mem_addr_o <= stack_pointer[23:0] - STACK_WORD;
							mem_wdata_o <= adv ? {8'h00, pc[23:16]} : pc[15:0];
						end
						if (adv && step == 20'h00002) begin
							mem_req_o <= 1'b1;
							mem_we_o <= 1'b1;
							mem_addr_o <= stack_pointer[23:0] - 24'h000004;
							mem_wdata_o <= pc[15:0];
						end
						if (step == 20'h00004) begin // RL1
							mem_req_o <= 1'b1;
							mem_we_o <= 1'b1;
							mem_addr_o <= stack_pointer[23:0] - (adv ? 24'h000006 : 24'h000004);
							mem_wdata_o <= {flag_register, flag_register};
						end
						if (step == 20'h00006 || (adv && step == 20'h00008)) begin
							mem_req_o <= 1'b1;
							mem_addr_o <= TRAP_VECTOR_BASE + {20'h00000, imm[1:0], 2'h0}
								+ ((step == 20'h00008) ? STACK_WORD : 24'h000000);
						end
					end
					exception_return_op: begin
						if (step == 20'h00000 || step == 20'h00002 || (adv && step == 20'h00004)) begin
							mem_req_o <= 1'b1; // RL2
							mem_addr_o <= stack_pointer[23:0] + {20'h00000, step[3:0]};
						end
					end
					flag_load_op: if (step == 20'h00000 && mode != mode_imm && mode != mode_reg) begin
						mem_req_o <= 1'b1; // RL5
						mem_addr_o <= ea;
					end
					flag_store_op: if (step == 20'h00000 && mode != mode_imm && mode != mode_reg) begin
						mem_req_o <= 1'b1; // RL6
						mem_we_o <= 1'b1;
						mem_addr_o <= ea; // RL7
						mem_wdata_o <= {flag_register, flag_register};
					end
					default: if (in_loop && step[1:0] == 2'h0) begin
						mem_req_o <= 1'b1; // RL8 RL9
						mem_byte_o <= 1'b1;
						mem_addr_o <= {8'h00, src};
					end else if (in_loop && step[1:0] == 2'h2) begin
						mem_req_o <= 1'b1;
						mem_we_o <= 1'b1;
						mem_byte_o <= 1'b1;
						mem_addr_o <= {8'h00, dst};
						mem_wdata_o <= {8'h00, mem_rdata_i[7:0]};
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pointer <= 32'h00000000;
			count <= 16'h0000;
			src <= 16'h0000;
			dst <= 16'h0000;
			byte_reg <= 8'h00;
			moved <= 16'h0000;
		end else if (accept) begin
			pointer <= cmd_pointer_i;
			count <= cmd_count_i;
			src <= cmd_src_i;
			dst <= cmd_dst_i;
			moved <= 16'h0000;
		end else if (busy) begin
			if (step == 20'h00000 && mode == mode_step && op == flag_load_op)
				pointer <= pointer + POINTER_STEP; // RL5
			if (step == 20'h00000 && mode == mode_step && op == flag_store_op)
				pointer <= pointer - POINTER_STEP; // RL7
			if (step == 20'h00000 && mode == mode_reg && op == flag_store_op)
				byte_reg <= flag_register; // RL6
			if (in_loop && step[1:0] == 2'h3) begin
				src <= src + 16'h0001; // RL8
				dst <= dst + 16'h0001;
				moved <= moved + 16'h0001;
				if (op == block_byte_move_op) count[7:0] <= count[7:0] - 8'h01; // RL8
				else count <= count - 16'h0001; // RL9
			end
		end
	end

	// two-entry result buffer: head feeds the ports directly, tail absorbs one stall
	assign entry = '{flag: flag_register, pc: pc, pointer: pointer, byte_reg: byte_reg,
		count: count, src: src, dst: dst};
	always_comb begin
		next_head_valid = head_valid;
		next_tail_valid = tail_valid;
		if (res_valid_o && res_ready_i) begin
			next_head_valid = tail_valid || done;
			next_tail_valid = tail_valid && done;
		end else if (done) begin
			next_head_valid = 1'b1;
			next_tail_valid = head_valid;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			head_valid <= 1'b0;
			tail_valid <= 1'b0;
			head <= '0;
			tail <= '0;
			cmd_ready_o <= 1'b0;
		end else begin
			head_valid <= next_head_valid;
			tail_valid <= next_tail_valid;
			if (res_valid_o && res_ready_i) begin
				head <= tail_valid ? tail : entry;
				if (tail_valid && done) tail <= entry;
			end else if (done) begin
				if (head_valid) tail <= entry;
				else head <= entry;
			end
			// one instruction in flight and a free slot keep the buffer from overflowing
			cmd_ready_o <= !next_tail_valid && !accept && (!busy || done) && !power_down_o;
		end
	end

	assign res_valid_o = head_valid;
	assign res_flag_o = head.flag;
	assign res_pc_o = head.pc;
	assign res_pointer_o = head.pointer;
	assign res_byte_o = head.byte_reg;
	assign res_count_o = head.count;
	assign res_src_o = head.src;
	assign res_dst_o = head.dst;
	assign flag_o = flag_register;
	assign pc_o = pc;
	assign sp_o = stack_pointer;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence trap_start;
		accept && cmd_op_i == software_trap_op && !cmd_advanced_i;
	endsequence
	sequence flag_pop;
		mem_req_o && !mem_we_o && mem_addr_o == stack_pointer[23:0];
	endsequence
	// done lands 14 edges after the accepting edge; the wait is split to keep repeats short
	a_trap_normal_time: assert property (trap_start |-> ##1 !done [*8] ##1 !done [*5] ##1 done) // RL1
		else $error("trap did not finish in 14 states");
	a_trap_sets_mask: assert property (done && op == software_trap_op |-> flag_register[7]) // RL1
		else $error("trap left interrupt mask clear");
	a_return_pops_flag: assert property (accept && cmd_op_i == exception_return_op
		|-> ##2 flag_pop ##2 (flag_register == $past(mem_rdata_i[15:8]))) // RL2
		else $error("return did not pop flags first");
	a_sleep_keeps_flags: assert property (accept && cmd_op_i == power_down_op |-> ##2
		(done && power_down_o && flag_register == $past(flag_register, 2))) // RL3
		else $error("power-down timing or flags wrong");
	a_load_immediate: assert property (accept && cmd_op_i == flag_load_op && cmd_mode_i == mode_imm
		|-> ##2 (done && flag_register == $past(cmd_imm_i, 2))) // RL4
		else $error("flag load from immediate wrong");
	a_postinc_pointer: assert property (done && op == flag_load_op && mode == mode_step
		|-> pointer[23:0] == ea + STACK_WORD) // RL5
		else $error("post-increment pointer not advanced by 2");
	a_store_keeps_flags: assert property (busy && op == flag_store_op |=> $stable(flag_register)) // RL6
		else $error("flag store changed flags");
	a_predec_write: assert property (busy && op == flag_store_op && mode == mode_step
		&& step == 20'h00000 |=> (mem_we_o && mem_addr_o == pointer[23:0])) // RL7
		else $error("pre-decrement store not at updated pointer");
	a_move_zero_skip: assert property (accept && cmd_op_i == block_byte_move_op
		&& cmd_count_i[7:0] == 8'h00 |-> ##1 (!done && !mem_req_o) [*7] ##1 done) // RL8
		else $error("zero-count move did not skip in 8 states");
	a_word_count_step: assert property (busy && op == block_word_move_op && in_loop
		&& step[1:0] == 2'h3 |=> count == $past(count) - 16'h0001) // RL9
		else $error("word count not decremented");
	a_move_time: assert property (done && is_move
		|-> step + 20'h00001 == STATES_MOVE_BASE + {2'h0, moved, 2'h0}) // RL10
		else $error("move time not 8 plus 4 per byte");
	a_and_immediate: assert property (accept && cmd_op_i == flag_and_immediate_op
		|-> ##2 flag_register == ($past(flag_register, 2) & $past(cmd_imm_i, 2))) // RL12
		else $error("flag and-immediate wrong");
endmodule : cpu_sysctl_and_block_move

/* inc/sysctl_pkg.sv */
// constants and types for the system control and block move execution unit
// assumes single-cycle on-chip memory with 16-bit words and read data one cycle after request
package sysctl_pkg;
	typedef enum logic [3:0] {
		nop_op, software_trap_op, exception_return_op, power_down_op,
		flag_load_op, flag_store_op, flag_and_immediate_op, flag_or_immediate_op,
		flag_xor_immediate_op, block_byte_move_op, block_word_move_op
	} op_type;
	// operand forms; mode_step is post-increment for loads, pre-decrement for stores
	typedef enum logic [2:0] {
		mode_imm, mode_reg, mode_ind, mode_disp16, mode_disp24, mode_step, mode_abs16, mode_abs24
	} mode_type;
	typedef struct packed {
		logic [7:0] flag;
		logic [23:0] pc;
		logic [31:0] pointer;
		logic [7:0] byte_reg;
		logic [15:0] count;
		logic [15:0] src;
		logic [15:0] dst;
	} result_type;
	localparam int STEP_WIDTH = 20;
	localparam logic [19:0] STATES_SHORT = 20'h00002;
	localparam logic [19:0] STATES_TRAP_NORMAL = 20'h0000E;
	localparam logic [19:0] STATES_TRAP_ADVANCED = 20'h00010;
	localparam logic [19:0] STATES_RETURN = 20'h0000A;
	localparam logic [19:0] STATES_MEM_IND = 20'h00006;
	localparam logic [19:0] STATES_MEM_DISP16 = 20'h00008;
	localparam logic [19:0] STATES_MEM_DISP24 = 20'h0000C;
	localparam logic [19:0] STATES_MEM_STEP = 20'h00008;
	localparam logic [19:0] STATES_MEM_ABS16 = 20'h00008;
	localparam logic [19:0] STATES_MEM_ABS24 = 20'h0000A;
	localparam logic [19:0] STATES_MOVE_BASE = 20'h00008;
	localparam logic [19:0] STATES_MOVE_LOOP_START = 20'h00004;
	localparam logic [31:0] POINTER_STEP = 32'h00000002;
	localparam logic [23:0] STACK_WORD = 24'h000002;
	localparam int I_FLAG_BIT = 7;
	// vector table base and stack reset are arbitrary defaults
	localparam logic [23:0] TRAP_VECTOR_BASE = 24'h000010;
	localparam logic [31:0] STACK_RESET = 32'h0000FF00;
endpackage : sysctl_pkg

/* test/mem_model.sv */
// on-chip memory partner: byte addressed, big-endian words, no wait states
// assumes one-cycle request pulses and read data taken in the cycle after the request
`timescale 1ns/1ps
module mem_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic byte_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o
);
	logic [7:0] mem [logic [23:0]];
	// unwritten bytes give an address pattern so a wrong address shows
	function automatic logic [7:0] rd(input logic [23:0] a);
		return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'hA5);
	endfunction : rd
	initial rdata_o = 16'h0000;
	always @(posedge clk_i) begin
		if (req_i && we_i && byte_i) begin
			mem[addr_i] = wdata_i[7:0];
		end else if (req_i && we_i) begin
			mem[addr_i] = wdata_i[15:8];
			mem[addr_i + 24'h000001] = wdata_i[7:0];
		end
		if (req_i && !we_i) begin
			rdata_o <= byte_i ? {2{rd(addr_i)}} : {rd(addr_i), rd(addr_i + 24'h000001)};
		end else begin
			// read slot over: never leave stale data on the bus
			rdata_o <= ~rdata_o;
		end
	end
endmodule : mem_model

/* test/testbench.sv */
// self-checking bench for the system control and block move unit
// assumes the memory partner answers every request without wait states
`timescale 1ns/1ps
module testbench import sysctl_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, adv = 1'b0, wake = 1'b0, res_ready = 1'b0;
	op_type op = nop_op;
	mode_type mode = mode_imm;
	logic [7:0] imm = 8'h00;
	logic [23:0] disp = 24'h000000;
	logic [31:0] ptr = 32'h00000000;
	logic [15:0] cnt = 16'h0000, src = 16'h0000, dst = 16'h0000, rdata, wdata;
	logic cmd_ready, mem_req, mem_we, mem_byte, pdown, res_valid;
	logic [23:0] mem_addr, pc, res_pc, exp_pc;
	logic [15:0] res_count, res_src, res_dst;
	logic [7:0] flag, res_flag, res_byte;
	logic [31:0] sp, res_ptr;
	int miscompares = 0, n_compared = 0;
	always #5 clk = ~clk;
	cpu_sysctl_and_block_move dut (.clk_i(clk), .sys_rst_i(rst), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_op_i(op), .cmd_mode_i(mode), .cmd_advanced_i(adv),
		.cmd_imm_i(imm), .cmd_disp_i(disp), .cmd_pointer_i(ptr), .cmd_count_i(cnt),
		.cmd_src_i(src), .cmd_dst_i(dst), .wake_i(wake), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_byte_o(mem_byte), .mem_addr_o(mem_addr), .mem_wdata_o(wdata), .mem_rdata_i(rdata),
		.power_down_o(pdown), .flag_o(flag), .pc_o(pc), .sp_o(sp), .res_valid_o(res_valid),
		.res_ready_i(res_ready), .res_flag_o(res_flag), .res_pc_o(res_pc), .res_pointer_o(res_ptr),
		.res_byte_o(res_byte), .res_count_o(res_count), .res_src_o(res_src), .res_dst_o(res_dst));
	mem_model mem_i (.clk_i(clk), .req_i(mem_req), .we_i(mem_we), .byte_i(mem_byte),
		.addr_i(mem_addr), .wdata_i(wdata), .rdata_o(rdata));
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task automatic timeout;
		miscompares++;
		$display("BAD %0t wait bound used up", $time);
		close_out();
	endtask : timeout
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chk_states(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			miscompares++;
			$display("BAD %0t state count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_states
	function automatic logic [7:0] peek(input logic [23:0] a);
		return mem_i.rd(a);
	endfunction : peek
	task automatic issue;
		int k;
		k = 0;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		if (k == 300) timeout();
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask : issue
	// result shows in cycle A+N+1 after the accepting edge A
	task automatic run(input int n);
		int k;
		issue();
		k = 1;
		while (res_valid !== 1'b1 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		if (k == 2000) timeout();
		chk_states(k - 1, n);
	endtask : run
	task automatic take;
		res_ready = 1'b1;
		@(negedge clk);
		res_ready = 1'b0;
	endtask : take
	task automatic load_imm(input logic [7:0] v);
		op = flag_load_op;
		mode = mode_imm;
		imm = v;
		run(2);
		take();
	endtask : load_imm
	task automatic t_nop;
		op = nop_op;
		run(2);
		exp_pc = 24'h000002;
		chk(res_pc, exp_pc, "nop pc");
		chk(res_flag, 8'h80, "nop flags");
		take();
		$display("test nop finished");
	endtask : t_nop
	task automatic t_flags;
		op_type ops[6] = '{flag_load_op, flag_and_immediate_op, flag_or_immediate_op,
			flag_xor_immediate_op, flag_load_op, flag_store_op};
		logic [7:0] ims[6] = '{8'h0F, 8'h3C, 8'h81, 8'hFF, 8'h55, 8'h00};
		logic [7:0] exps[6] = '{8'h0F, 8'h0C, 8'h8D, 8'h72, 8'h55, 8'h55};
		for (int i = 0; i < 6; i++) begin
			op = ops[i];
			mode = (i < 4) ? mode_imm : mode_reg;
			imm = ims[i];
			run(2);
			chk(res_flag, exps[i], "flag op");
			if (i == 5) chk(res_byte, 8'h55, "store to byte register");
			take();
		end
		$display("test flag ops finished");
	endtask : t_flags
	task automatic t_mem_forms;
		mode_type md[5] = '{mode_ind, mode_disp16, mode_disp24, mode_abs16, mode_abs24};
		int ns[5] = '{6, 8, 12, 8, 10};
		logic [23:0] a;
		ptr = 32'h00000200;
		disp = 24'h000400;
		for (int i = 0; i < 5; i++) begin
			a = (i == 0) ? 24'h000200 : ((i < 3) ? 24'h000600 : 24'h000400);
			mem_i.mem[a] = 8'h40 + 8'(i);
			mem_i.mem[a + 24'h000001] = 8'h40 + 8'(i);
			op = flag_load_op;
			mode = md[i];
			run(ns[i]);
			chk(res_flag, 8'h40 + 8'(i), "load form");
			take();
		end
		load_imm(8'h33);
		op = flag_store_op;
		mode = mode_step;
		ptr = 32'h00000500;
		run(8);
		chk(res_ptr, 32'h000004FE, "predecrement pointer");
		chk({peek(24'h0004FE), peek(24'h0004FF)}, 16'h3333, "predecrement word");
		chk(res_flag, 8'h33, "store keeps flags");
		take();
		load_imm(8'h00);
		mode = mode_step;
		ptr = 32'h000004FE;
		run(8);
		chk(res_flag, 8'h33, "postincrement load");
		chk(res_ptr, 32'h00000500, "postincrement pointer");
		take();
		$display("test memory forms finished");
	endtask : t_mem_forms
	task automatic t_trap;
		load_imm(8'h15);
		op = software_trap_op;
		imm = 8'h00;
		run(14);
		chk(flag[7], 1'b1, "mask set");
		chk(sp, 32'h0000FEFC, "trap stack");
		chk({peek(24'h00FEFC), peek(24'h00FEFE), peek(24'h00FEFF)}, 24'h150002, "pushed");
		take();
		op = exception_return_op;
		run(10);
		chk(res_flag, 8'h15, "restored flags");
		chk(res_pc, exp_pc, "restored pc");
		chk(sp, 32'h0000FF00, "return stack");
		take();
		mem_i.mem[24'h000014] = 8'h00;
		mem_i.mem[24'h000015] = 8'h12;
		mem_i.mem[24'h000016] = 8'h34;
		mem_i.mem[24'h000017] = 8'h56;
		op = software_trap_op;
		imm = 8'h01;
		adv = 1'b1;
		run(16);
		exp_pc = 24'h123456;
		chk(res_pc, exp_pc, "vector pc");
		chk(pc, exp_pc, "pc out");
		chk(sp, 32'h0000FEFA, "advanced stack");
		chk({peek(24'h00FEFA), peek(24'h00FEFB)}, 16'h1515, "pushed flags");
		take();
		adv = 1'b0;
		$display("test trap finished");
	endtask : t_trap
	task automatic t_sleep;
		int k;
		op = power_down_op;
		run(2);
		chk(res_flag, 8'h95, "sleep flags");
		take();
		chk(pdown, 1'b1, "asleep");
		chk(cmd_ready, 1'b0, "asleep refuses");
		wake = 1'b1;
		k = 0;
		while (pdown !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		if (k == 20) timeout();
		wake = 1'b0;
		$display("test sleep finished");
	endtask : t_sleep
	task automatic t_move;
		mem_i.mem[24'h000300] = 8'hA1;
		mem_i.mem[24'h000301] = 8'hB2;
		mem_i.mem[24'h000302] = 8'hC3;
		op = block_byte_move_op;
		cnt = 16'hFF03;
		src = 16'h0300;
		dst = 16'h0380;
		run(20);
		chk({res_src, res_dst}, 32'h03030383, "byte move pointers");
		chk(res_count[7:0], 8'h00, "byte move count");
		chk({peek(24'h380), peek(24'h381), peek(24'h382), peek(24'h383)}, 32'hA1B2C326,
			"byte move data");
		take();
		cnt = 16'h0100;
		dst = 16'h03C0;
		run(8);
		chk({res_dst, peek(24'h0003C0)}, 24'h03C065, "zero count skip");
		take();
		op = block_word_move_op;
		cnt = 16'h0002;
		dst = 16'h03E0;
		run(16);
		chk(res_count, 16'h0000, "word move count");
		chk({peek(24'h3E0), peek(24'h3E1), peek(24'h3E2)}, 24'hA1B247, "word move data");
		take();
		$display("test block move finished");
	endtask : t_move
	task automatic t_buffer;
		int k;
		op = nop_op;
		issue();
		@(negedge clk);
		issue();
		@(negedge clk);
		// a third command must wait while both buffer entries are held
		cmd_valid = 1'b1;
		k = 0;
		repeat (12) begin
			@(negedge clk);
			if (cmd_ready === 1'b1) k++;
		end
		cmd_valid = 1'b0;
		chk(32'(k), 32'h00000000, "full buffer refuses");
		chk(res_pc, exp_pc + 24'h000002, "buffer head");
		take();
		chk(res_pc, exp_pc + 24'h000004, "buffer tail");
		take();
		chk(res_valid, 1'b0, "buffer empty");
		$display("test buffer finished");
	endtask : t_buffer
	initial begin
		repeat (8) @(negedge clk);
		chk(flag, 8'h80, "reset flags");
		chk(sp, 32'h0000FF00, "reset stack");
		chk({res_valid, pdown}, 2'b00, "reset flags out");
		rst = 1'b0;
		t_nop();
		t_flags();
		t_mem_forms();
		t_trap();
		t_sleep();
		t_move();
		t_buffer();
		close_out();
	end
endmodule : testbench
